//--- link_sync.sv
`timescale 1ns/1ps
module link_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // Two-stage synchroniser plus one stage for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edges come only from synchronised copies
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;

endmodule

//--- serial_voltage_code_decoder.sv
`timescale 1ns/1ps
// Functional notes
// R1: Enable rising with power-good low captures both link pins as startup code.
// R2: Both DAC codes follow the startup code until power-good rises.
// R3: Startup code is kept and reapplied whenever power-good falls again.
// R4: Link traffic is ignored until power-good is high.
// R5: Address and data each arrive as eight serial bits.
// R6: Three addresses select core only, aux only, or both DACs.
// R7: Data bit 7 drives the power-save output; low means power saving.
// R8: Data bits 6..0 become the code of each selected DAC.
// R9: Enable rising with fixed mode high captures link pins as fixed code.
// R10: In fixed mode both DACs take the decoded fixed code.
// R11: Startup decode, clock pin high bit: 1.1, 1.0, 0.9, 0.8 V.
// R12: Fixed decode, clock pin high bit: 1.4, 1.2, 1.0, 0.8 V.
// R13: Start is data fall with clock high; matching write address is acknowledged.
// R14: Data word is acknowledged and targets update at once unless off code.
// R15: Link pins are synchronised and edge-detected before any decoding.
module serial_voltage_id_decoder
  import voltage_code_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  input  wire logic       ENABLE_I,
  input  wire logic       HOST_POWER_GOOD_IN_I,
  input  wire logic       FIXED_VOLTAGE_MODE_I,
  input  wire logic       VOLTAGE_LINK_CLOCK_I,
  input  wire logic       VOLTAGE_LINK_DATA_I,
  output logic            VOLTAGE_LINK_DATA_O,
  output logic            VOLTAGE_LINK_DATA_OE_O,
  output logic [6:0]      CORE_REFERENCE_DAC_O,
  output logic [6:0]      AUX_REFERENCE_DAC_O,
  output logic            POWER_SAVE_INDICATOR_N_O,
  output logic            CONVERTER_OFF_O
);

  logic       rst_meta_q;
  logic       rst_n_q;
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic       lk_clk;
  logic       lk_dat;
  logic       pg;
  logic       fixed_in;
  logic       start_ev;
  logic       stop_ev;

  // Reset release through two flip-flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // All pins enter through the synchroniser
  link_sync #(.WIDTH(5)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n_q),
    .async_i ({ENABLE_I, FIXED_VOLTAGE_MODE_I, HOST_POWER_GOOD_IN_I,
               VOLTAGE_LINK_CLOCK_I, VOLTAGE_LINK_DATA_I}),   // see R15
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // Named views of the synchronised pins
  assign lk_dat   = pin_lvl[0];
  assign lk_clk   = pin_lvl[1];
  assign pg       = pin_lvl[2];
  assign fixed_in = pin_lvl[3];
  assign start_ev = pin_fall[0] & lk_clk;                      // see R13
  assign stop_ev  = pin_rise[0] & lk_clk;

  // Receiver state
  rx_state_t  st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] sel_q, sel_d;
  logic       oe_q, oe_d;
  logic       upd_q, upd_d;
  logic       dat_q;
  logic       fixed_q, fixed_d;

  // Serial receiver: bits taken at link clock rise, ack driven from a fall
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    sel_d   = sel_q;
    oe_d    = oe_q;
    upd_d   = 1'b0;
    if (!pg || fixed_q) begin                                  // see R4
      st_d = RX_IDLE;
      oe_d = 1'b0;
    end else if (start_ev) begin
      st_d  = RX_ADDR;
      cnt_d = 3'h0;
      oe_d  = 1'b0;
    end else if (stop_ev) begin
      st_d = RX_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        RX_ADDR, RX_DATA: begin
          if (pin_rise[1]) begin
            shift_d = {shift_q[6:0], lk_dat};                  // see R5
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == LAST_BIT) begin
              st_d = (st_q == RX_ADDR) ? RX_ADDR_END : RX_DATA_END;
            end
          end
        end
        RX_ADDR_END: begin
          if (pin_fall[1]) begin
            st_d = RX_IDLE;
            if (shift_q[0] == 1'b0) begin                      // see R13
              if (shift_q[7:1] == ADDR_CORE_ONLY) begin        // see R6
                sel_d = 2'b10;
                st_d  = RX_ACK_ADDR;
              end else if (shift_q[7:1] == ADDR_AUX_ONLY) begin
                sel_d = 2'b01;
                st_d  = RX_ACK_ADDR;
              end else if (shift_q[7:1] == ADDR_BOTH) begin
                sel_d = 2'b11;
                st_d  = RX_ACK_ADDR;
              end
            end
            oe_d = (st_d == RX_ACK_ADDR);
          end
        end
        RX_ACK_ADDR: begin
          if (pin_fall[1]) begin
            oe_d  = 1'b0;
            cnt_d = 3'h0;
            st_d  = RX_DATA;
          end
        end
        RX_DATA_END: begin
          if (pin_fall[1]) begin
            oe_d  = 1'b1;                                      // see R14
            upd_d = 1'b1;
            st_d  = RX_ACK_DATA;
          end
        end
        RX_ACK_DATA: begin
          if (pin_fall[1]) begin
            oe_d = 1'b0;
            st_d = RX_IDLE;
          end
        end
        default: begin
          st_d = RX_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= RX_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      sel_q   <= 2'h0;
      oe_q    <= 1'b0;
      upd_q   <= 1'b0;
      dat_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      sel_q   <= sel_d;
      oe_q    <= oe_d;
      upd_q   <= upd_d;
      dat_q   <= 1'b0;
    end
  end

  // Mode, captured codes and DAC targets
  logic [1:0] boot_pins_q, boot_pins_d;
  logic [1:0] fix_pins_q, fix_pins_d;
  dac_pair_t  tgt_q, tgt_d;
  dac_pair_t  dac_q, dac_d;
  logic       psi_n_q, psi_n_d;
  logic       off_q, off_d;
  logic [6:0] new_code;

  assign new_code = shift_q[CODE_MSB:0];

  // Capture at enable rise, then pick the source for both DACs
  always_comb begin
    fixed_d     = fixed_q;
    boot_pins_d = boot_pins_q;
    fix_pins_d  = fix_pins_q;
    tgt_d       = tgt_q;
    psi_n_d     = psi_n_q;
    off_d       = off_q;
    if (pin_rise[4]) begin
      fixed_d = fixed_in;
      if (fixed_in) begin
        fix_pins_d = {lk_clk, lk_dat};                         // see R9
      end else if (!pg) begin
        boot_pins_d = {lk_clk, lk_dat};                        // see R1
      end
    end
    if (!pg) begin
      tgt_d.core = boot_decode(boot_pins_q);                   // see R3
      tgt_d.aux  = boot_decode(boot_pins_q);
      psi_n_d    = 1'b1;
      off_d      = 1'b0;
    end else if (upd_q) begin
      psi_n_d = shift_q[PSI_BIT];                              // see R7
      if (new_code >= OFF_CODE_FIRST) begin
        off_d = 1'b1;                                          // see R14
      end else begin
        off_d = 1'b0;
        if (sel_q[1]) begin
          tgt_d.core = new_code;                               // see R8
        end
        if (sel_q[0]) begin
          tgt_d.aux = new_code;                                // see R6
        end
      end
    end
    if (fixed_q) begin
      dac_d.core = fix_decode(fix_pins_q);                     // see R10 R12
      dac_d.aux  = fix_decode(fix_pins_q);
    end else if (!pg) begin
      dac_d.core = boot_decode(boot_pins_q);                   // see R2 R11
      dac_d.aux  = boot_decode(boot_pins_q);
    end else begin
      dac_d = tgt_q;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fixed_q     <= 1'b0;
      boot_pins_q <= PINS_RESET;
      fix_pins_q  <= PINS_RESET;
      tgt_q       <= {DAC_RESET, DAC_RESET};
      dac_q       <= {DAC_RESET, DAC_RESET};
      psi_n_q     <= 1'b1;
      off_q       <= 1'b0;
    end else begin
      fixed_q     <= fixed_d;
      boot_pins_q <= boot_pins_d;
      fix_pins_q  <= fix_pins_d;
      tgt_q       <= tgt_d;
      dac_q       <= dac_d;
      psi_n_q     <= psi_n_d;
      off_q       <= off_d;
    end
  end

  // Outputs straight from flip-flops
  assign VOLTAGE_LINK_DATA_O      = dat_q;
  assign VOLTAGE_LINK_DATA_OE_O   = oe_q;
  assign CORE_REFERENCE_DAC_O     = dac_q.core;
  assign AUX_REFERENCE_DAC_O      = dac_q.aux;
  assign POWER_SAVE_INDICATOR_N_O = psi_n_q;
  assign CONVERTER_OFF_O          = off_q;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n_q);

  chk_boot_capture: assert property (pin_rise[4] && !fixed_in && !pg  // see R1
    |=> boot_pins_q == $past({lk_clk, lk_dat})) else $error("startup code not captured");
  chk_boot_hold: assert property (!fixed_q && !pg  // see R2
    |=> dac_q.core == boot_decode($past(boot_pins_q)) && dac_q.aux == dac_q.core)
    else $error("DACs do not follow startup code");
  chk_boot_reapply: assert property ($fell(pg) && !fixed_q  // see R3
    |=> ##1 tgt_q.core == boot_decode(boot_pins_q)) else $error("startup code not reapplied");
  chk_link_ignored: assert property (!pg |=> !oe_q && !upd_q)  // see R4
    else $error("link acted on before power good");
  chk_addr_ack: assert property ($rose(oe_q) && st_q == RX_ACK_ADDR  // see R13
    |-> !shift_q[0] && (shift_q[7:1] == ADDR_CORE_ONLY || shift_q[7:1] == ADDR_AUX_ONLY
        || shift_q[7:1] == ADDR_BOTH)) else $error("ack for foreign address");
  chk_psi_update: assert property (upd_q && pg  // see R7
    |=> psi_n_q == $past(shift_q[PSI_BIT])) else $error("power save bit not applied");
  chk_core_update: assert property (upd_q && pg && sel_q[1] && new_code < OFF_CODE_FIRST  // see R8
    |=> tgt_q.core == $past(new_code) ##1 (fixed_q || !pg || dac_q.core == $past(new_code, 2)))
    else $error("core code not updated");
  chk_aux_keep: assert property (upd_q && pg && !sel_q[0]  // see R6
    |=> $stable(tgt_q.aux)) else $error("aux changed by core-only address");
  chk_off_keep: assert property (upd_q && pg && new_code >= OFF_CODE_FIRST  // see R14
    |=> off_q && $stable(tgt_q)) else $error("off command changed targets");
  chk_fixed_code: assert property (fixed_q  // see R10
    |=> dac_q.core == fix_decode($past(fix_pins_q)) && dac_q.aux == dac_q.core)
    else $error("fixed code not applied");
  chk_fixed_capture: assert property (pin_rise[4] && fixed_in  // see R9
    |=> fixed_q && fix_pins_q == $past({lk_clk, lk_dat})) else $error("fixed code not captured");
  chk_ack_len: assert property ($rose(oe_q) |-> oe_q [*3])  // see R14
    else $error("ack too short");

  cov_boot: cover property (pin_rise[4] && !fixed_in && !pg);
  cov_fixed: cover property (pin_rise[4] && fixed_in);
  cov_update: cover property (upd_q && pg && sel_q == 2'b11);
  cov_reapply: cover property ($fell(pg) && !fixed_q);

endmodule

//--- serial_voltage_code_decoder_tb.sv
`timescale 1ns/1ps
module serial_voltage_id_decoder_tb;
  import voltage_code_pkg::*;

  logic       clk;
  logic       nrst;
  logic       enable;
  logic       power_good;
  logic       fixed_mode;
  logic       link_clock;
  logic       link_data;
  logic       data_o;
  logic       data_oe;
  logic       dev_low;
  logic       psi_n;
  logic       conv_off;
  logic [6:0] core_dac;
  logic [6:0] aux_dac;
  int         n_fail;
  int         check_count;

  // Device pulls the data wire low while its enable is high
  assign dev_low = data_oe & ~data_o;

  serial_voltage_id_decoder i_serial_voltage_id_decoder (
    .CLK_I                    (clk),
    .NRST_I                   (nrst),
    .ENABLE_I                 (enable),
    .HOST_POWER_GOOD_IN_I     (power_good),
    .FIXED_VOLTAGE_MODE_I     (fixed_mode),
    .VOLTAGE_LINK_CLOCK_I     (link_clock),
    .VOLTAGE_LINK_DATA_I      (link_data),
    .VOLTAGE_LINK_DATA_O      (data_o),
    .VOLTAGE_LINK_DATA_OE_O   (data_oe),
    .CORE_REFERENCE_DAC_O     (core_dac),
    .AUX_REFERENCE_DAC_O      (aux_dac),
    .POWER_SAVE_INDICATOR_N_O (psi_n),
    .CONVERTER_OFF_O          (conv_off)
  );

  voltage_host_model i_voltage_host_model (
    .clk_i        (clk),
    .dev_low_i    (dev_low),
    .link_clock_o (link_clock),
    .link_data_o  (link_data)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Verdict and end of run
  task automatic results();
    $display("Comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare a 7-bit code
  task automatic check_code(input string name, input logic [6:0] exp, input logic [6:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compare a single bit
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Bounded wait for both DAC codes, then compare them
  task automatic expect_dacs(input logic [6:0] core_exp, input logic [6:0] aux_exp);
    int k;
    k = 0;
    while ((core_dac !== core_exp || aux_dac !== aux_exp) && k < 20) begin
      @(negedge clk);
      k++;
    end
    check_code("core dac", core_exp, core_dac);
    check_code("aux dac", aux_exp, aux_dac);
    if (core_dac !== core_exp || aux_dac !== aux_exp) begin
      results();
    end
  endtask

  // Enable strobe with given pin levels and mode
  task automatic capture(input logic fixed, input logic [1:0] pins);
    @(negedge clk);
    enable     = 1'b0;
    fixed_mode = fixed;
    i_voltage_host_model.set_pins(pins);
    repeat (6) @(negedge clk);
    enable = 1'b1;
  endtask

  // One link command and its results
  task automatic cmd(input logic [7:0] addr, input logic [7:0] data, input logic ack,
                     input logic [6:0] core_exp, input logic [6:0] aux_exp,
                     input logic psi_exp, input logic off_exp);
    logic ack_a;
    logic ack_d;
    i_voltage_host_model.send(addr, data, ack_a, ack_d);
    check_bit("address ack", ack, ack_a);
    check_bit("data ack", ack, ack_d);
    check_code("core dac", core_exp, core_dac);
    check_code("aux dac", aux_exp, aux_dac);
    check_bit("power save", psi_exp, psi_n);
    check_bit("converter off", off_exp, conv_off);
  endtask

  // All four startup codes, each differing from the one before
  task automatic t_startup();
    logic [6:0] tab [4] = '{BOOT_CODE_00, BOOT_CODE_01, BOOT_CODE_10, BOOT_CODE_11};
    power_good = 1'b0;
    for (int p = 3; p >= 0; p--) begin
      capture(1'b0, 2'(p));
      expect_dacs(tab[p], tab[p]);
    end
  endtask

  // All four fixed-voltage codes
  task automatic t_fixed();
    logic [6:0] tab [4] = '{FIX_CODE_00, FIX_CODE_01, FIX_CODE_10, FIX_CODE_11};
    power_good = 1'b1;
    for (int p = 0; p < 4; p++) begin
      capture(1'b1, 2'(p));
      expect_dacs(tab[p], tab[p]);
    end
    power_good = 1'b0;
    capture(1'b0, 2'h1);
    expect_dacs(BOOT_CODE_01, BOOT_CODE_01);
  endtask

  // Traffic before power-good is not answered and changes nothing
  task automatic t_ignored();
    cmd({ADDR_BOTH, 1'b0}, 8'h85, 1'b0, BOOT_CODE_01, BOOT_CODE_01, 1'b1, 1'b0);
  endtask

  // Addresses, power-save bit, off code, wrong address and read bit
  task automatic t_cmds();
    power_good = 1'b1;
    repeat (6) @(negedge clk);
    cmd({ADDR_CORE_ONLY, 1'b0}, 8'h05, 1'b1, 7'h05, BOOT_CODE_01, 1'b0, 1'b0);
    cmd({ADDR_AUX_ONLY, 1'b0}, 8'hC0, 1'b1, 7'h05, 7'h40, 1'b1, 1'b0);
    cmd({ADDR_BOTH, 1'b0}, 8'h7B, 1'b1, 7'h7B, 7'h7B, 1'b0, 1'b0);
    cmd({ADDR_BOTH, 1'b0}, 8'hFC, 1'b1, 7'h7B, 7'h7B, 1'b1, 1'b1);
    cmd({7'h13, 1'b0}, 8'h11, 1'b0, 7'h7B, 7'h7B, 1'b1, 1'b1);
    cmd({ADDR_CORE_ONLY, 1'b1}, 8'h11, 1'b0, 7'h7B, 7'h7B, 1'b1, 1'b1);
    cmd({ADDR_CORE_ONLY, 1'b0}, 8'h81, 1'b1, 7'h01, 7'h7B, 1'b1, 1'b0);
  endtask

  // Power-good loss brings back the stored startup code
  task automatic t_reapply();
    power_good = 1'b0;
    expect_dacs(BOOT_CODE_01, BOOT_CODE_01);
    power_good = 1'b1;
    repeat (6) @(negedge clk);
    cmd({ADDR_BOTH, 1'b0}, 8'h90, 1'b1, 7'h10, 7'h10, 1'b1, 1'b0);
  endtask

  // Reset, then the scenarios in order
  initial begin
    clk         = 1'b0;
    nrst        = 1'b0;
    enable      = 1'b0;
    power_good  = 1'b0;
    fixed_mode  = 1'b0;
    n_fail      = 0;
    check_count = 0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    t_startup();
    t_fixed();
    t_ignored();
    t_cmds();
    t_reapply();
    results();
  end
endmodule

//--- serial_voltage_code_host_model.sv
`timescale 1ns/1ps
module voltage_host_model (
  input  wire logic clk_i,
  input  wire logic dev_low_i,
  output logic      link_clock_o,
  output logic      link_data_o
);
  logic host_low;

  // Data wire is open drain with a pull-up, so released means high
  assign link_data_o = ~(host_low | dev_low_i);

  // Clock stands high and data is released between frames
  initial begin
    link_clock_o = 1'b1;
    host_low     = 1'b0;
  end

  // Half of the 200 ns link period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // Static pin levels for code capture, clock pin is the high bit
  task automatic set_pins(input logic [1:0] pins);
    link_clock_o = pins[1];
    host_low     = ~pins[0];
  endtask

  // One bit; data changes only while the clock is low
  task automatic put_bit(input logic b, output logic seen);
    host_low = ~b;
    half();
    link_clock_o = 1'b1;
    repeat (2) @(negedge clk_i);
    seen = link_data_o; // Wire level mid high phase
    repeat (2) @(negedge clk_i);
    link_clock_o = 1'b0;
  endtask

  // Start, address word, ack, data word, ack, stop; ack flags high when seen
  task automatic send(input logic [7:0] addr, input logic [7:0] data,
                      output logic ack_a, output logic ack_d);
    logic s;
    link_clock_o = 1'b1;
    host_low     = 1'b0;
    half();
    host_low = 1'b1; // Data falls while clock high
    half();
    link_clock_o = 1'b0;
    for (int i = 7; i >= 0; i--) put_bit(addr[i], s); // Eight bits, MSB first
    put_bit(1'b1, s);
    ack_a = ~s;
    for (int i = 7; i >= 0; i--) put_bit(data[i], s); // Eight bits, MSB first
    put_bit(1'b1, s);
    ack_d = ~s;
    host_low = 1'b1;
    half();
    link_clock_o = 1'b1;
    half();
    host_low = 1'b0; // Data rises while clock high ends the frame
    half();
  endtask
endmodule

//--- serial_voltage_code_pkg.sv
package voltage_code_pkg;

  // Link word and code widths
  localparam int WORD_BITS = 8;
  localparam int CODE_BITS = 7;
  localparam int ADDR_BITS = 7;

  // Receiver address table (values are arbitrary)
  localparam logic [6:0] ADDR_CORE_ONLY = 7'h10;
  localparam logic [6:0] ADDR_AUX_ONLY  = 7'h11;
  localparam logic [6:0] ADDR_BOTH      = 7'h12;

  // Data word fields
  localparam int PSI_BIT  = 7;
  localparam int CODE_MSB = 6;

  // Codes at or above this value turn the converter off
  localparam logic [6:0] OFF_CODE_FIRST = 7'h7C;

  // Startup codes: 1.1 V, 1.0 V, 0.9 V, 0.8 V
  localparam logic [6:0] BOOT_CODE_00 = 7'h24;
  localparam logic [6:0] BOOT_CODE_01 = 7'h2C;
  localparam logic [6:0] BOOT_CODE_10 = 7'h34;
  localparam logic [6:0] BOOT_CODE_11 = 7'h3C;

  // Fixed-voltage codes: 1.4 V, 1.2 V, 1.0 V, 0.8 V
  localparam logic [6:0] FIX_CODE_00 = 7'h0C;
  localparam logic [6:0] FIX_CODE_01 = 7'h1C;
  localparam logic [6:0] FIX_CODE_10 = 7'h2C;
  localparam logic [6:0] FIX_CODE_11 = 7'h3C;

  // Reset values and last bit index
  localparam logic [6:0] DAC_RESET   = 7'h00;
  localparam logic [1:0] PINS_RESET  = 2'h0;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE     = 3'b000,
    RX_ADDR     = 3'b001,
    RX_ADDR_END = 3'b010,
    RX_ACK_ADDR = 3'b011,
    RX_DATA     = 3'b100,
    RX_DATA_END = 3'b101,
    RX_ACK_DATA = 3'b110
  } rx_state_t;

  // Both reference codes travel together
  typedef struct packed {
    logic [6:0] core;
    logic [6:0] aux;
  } dac_pair_t;

  // Startup decode, clock pin level is the high bit
  function automatic logic [6:0] boot_decode(input logic [1:0] pins);
    logic [6:0] code;
    code = BOOT_CODE_00;
    case (pins)
      2'h1:    code = BOOT_CODE_01;
      2'h2:    code = BOOT_CODE_10;
      2'h3:    code = BOOT_CODE_11;
      default: code = BOOT_CODE_00;
    endcase
    return code;
  endfunction

  // Fixed-voltage decode, clock pin level is the high bit
  function automatic logic [6:0] fix_decode(input logic [1:0] pins);
    logic [6:0] code;
    code = FIX_CODE_00;
    case (pins)
      2'h1:    code = FIX_CODE_01;
      2'h2:    code = FIX_CODE_10;
      2'h3:    code = FIX_CODE_11;
      default: code = FIX_CODE_00;
    endcase
    return code;
  endfunction

endpackage
